// File: shared/rtps_frame_pkg.sv
/*
 * Constants for the message framing parser: header layout, submessage
 * header layout, identifier codes, flag masks and register map.
 * Assumes nothing; used by the parser, its port checker and its testbench.
 */
package rtps_frame_pkg;

    // Message header: magic, version, vendor, participant prefix
    localparam logic [7:0] MAGIC_0 = 8'h52;
    localparam logic [7:0] MAGIC_1 = 8'h54;
    localparam logic [7:0] MAGIC_2 = 8'h50;
    localparam logic [7:0] MAGIC_3 = 8'h53;
    localparam logic [4:0] POS_MAJOR = 5'h04;
    localparam logic [4:0] POS_VENDOR_HI = 5'h06;
    localparam logic [4:0] POS_VENDOR_LO = 5'h07;
    localparam logic [4:0] POS_HDR_LAST = 5'h13;
    localparam logic [7:0] VERSION_MAJOR = 8'h02;

    // Submessage header octet positions
    localparam logic [4:0] POS_SUB_ID = 5'h00;
    localparam logic [4:0] POS_SUB_FLAGS = 5'h01;
    localparam logic [4:0] POS_SUB_LEN_A = 5'h02;
    localparam logic [4:0] POS_SUB_LEN_B = 5'h03;

    // Identifiers and classes
    localparam logic [7:0] ID_NACK_FRAG = 8'h12;
    localparam logic [7:0] ID_HEARTBEAT_FRAG = 8'h13;
    localparam logic [7:0] ID_DATA = 8'h15;
    localparam logic [7:0] ID_DATA_FRAG = 8'h16;
    localparam logic [7:0] ID_PROTO_LAST = 8'h7f;
    localparam logic [7:0] ID_VENDOR_FIRST = 8'h80;

    // Flag masks
    localparam logic [7:0] FLAG_LITTLE = 8'h01;
    localparam logic [7:0] FLAG_FINAL = 8'h02;

    // Compact locator element: address then port, one ulong each
    localparam logic [3:0] LOC_OCTETS = 4'h8;

    // Register map and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SUB_COUNT = 8'h08;
    localparam logic [7:0] REG_ERR_COUNT = 8'h0c;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CLEAR = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    // Descriptor width: vendor 16, kind 4, last 1, id 8, flags 8, len 16
    localparam int DESC_W = 53;

    typedef enum logic [3:0] {
        K_PROTO_OTHER = 4'h0,
        K_NACK_FRAG = 4'h1,
        K_HEARTBEAT_FRAG = 4'h2,
        K_DATA = 4'h3,
        K_DATA_FRAG = 4'h4,
        K_ACKNACK = 4'h5,
        K_PAD = 4'h6,
        K_INFO_TS = 4'h7,
        K_VENDOR = 4'h8
    } kind_t;

    typedef enum logic [2:0] {
        S_HDR = 3'b000,
        S_SUB = 3'b001,
        S_BODY = 3'b010,
        S_TAIL = 3'b011,
        S_DROP = 3'b100
    } state_t;

endpackage : rtps_frame_pkg

// File: core/desc_buffer.sv
/*
 * Two-entry buffer with valid and ready on both sides; outputs come
 * straight from registers. Assumes one clock and a synchronised reset.
 */
`timescale 1ns/1ps
module desc_buffer #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] tail_data;
    logic tail_valid;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Head feeds the port, tail catches a word while the head stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
            tail_valid <= 1'b0;
            tail_data <= '0;
            in_ready <= 1'b1;
        end else begin
            if (pop || !out_valid) begin
                out_valid <= tail_valid | push;
                out_data <= tail_valid ? tail_data : in_data;
                tail_valid <= tail_valid & push;
                tail_data <= in_data;
                in_ready <= 1'b1;
            end else if (push) begin
                tail_valid <= 1'b1;
                tail_data <= in_data;
                in_ready <= 1'b0;
            end
        end
    end
endmodule : desc_buffer

// File: core/rtps_message_header_parser.sv
/*
 * Byte stream parser for publish-subscribe messages in UDP datagrams:
 * checks the message header, walks submessage headers and emits one
 * descriptor per submessage through a two-entry buffer.
 * Assumes a byte source on CLK_SYS with IN_LAST on the final octet of
 * each datagram, and a register master with single-cycle strobes.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module rtps_message_header_parser #(
    parameter logic [7:0] ACKNACK_ID = 8'h06,
    parameter logic [7:0] PAD_ID = 8'h01,
    parameter logic [7:0] INFO_TS_ID = 8'h09,
    parameter logic [7:0] LOC_ID = 8'h0f
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic IN_VALID,
    input wire logic [7:0] IN_DATA,
    input wire logic IN_LAST,
    output logic IN_READY,
    output logic SUB_VALID,
    input wire logic SUB_READY,
    output logic [7:0] SUB_ID,
    output logic [7:0] SUB_FLAGS,
    output logic [15:0] SUB_LEN,
    output logic [3:0] SUB_KIND,
    output logic [15:0] SUB_VENDOR,
    output logic SUB_LITTLE,
    output logic SUB_ACK_FINAL,
    output logic SUB_MSG_END,
    output logic LOC_VALID,
    output logic [31:0] LOC_ADDR,
    output logic [31:0] LOC_PORT,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);

    ////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Parser state
    rtps_frame_pkg::state_t state;
    rtps_frame_pkg::state_t next_state;
    logic [4:0] cnt;
    logic [15:0] rem;
    logic [7:0] id_r;
    logic [7:0] flags_r;
    logic [7:0] len_first;
    logic [15:0] len_r;
    logic [15:0] vendor_r;
    logic [7:0] major_r;
    logic [3:0] bidx;
    logic enable;
    logic [15:0] sub_count;
    logic [15:0] err_count;
    logic buf_ready;

    // Byte handshake and header checks
    wire fire = IN_VALID & buf_ready;
    wire in_hdr = state == rtps_frame_pkg::S_HDR;
    wire in_sub = state == rtps_frame_pkg::S_SUB;
    wire in_body = state == rtps_frame_pkg::S_BODY;
    wire in_tail = state == rtps_frame_pkg::S_TAIL;
    wire [7:0] magic_byte = (cnt[1:0] == 2'd0) ? rtps_frame_pkg::MAGIC_0 :
                            (cnt[1:0] == 2'd1) ? rtps_frame_pkg::MAGIC_1 :
                            (cnt[1:0] == 2'd2) ? rtps_frame_pkg::MAGIC_2 :
                            rtps_frame_pkg::MAGIC_3;
    wire magic_bad = (cnt < 5'd4) && (IN_DATA != magic_byte);
    wire major_bad = (cnt == rtps_frame_pkg::POS_MAJOR) &&
                     (IN_DATA != rtps_frame_pkg::VERSION_MAJOR);
    wire hdr_bad = in_hdr & fire & (magic_bad | major_bad | !enable);
    wire hdr_done = in_hdr & fire & !hdr_bad & !IN_LAST &
                    (cnt == rtps_frame_pkg::POS_HDR_LAST);

    // Length octets swapped by the endianness flag
    wire little = flags_r[0];
    wire [15:0] len_now = little ? {IN_DATA, len_first} : {len_first, IN_DATA};
    wire sub_hdr_end = in_sub & fire & (cnt == rtps_frame_pkg::POS_SUB_LEN_B);
    wire pad_like = (id_r == PAD_ID) || (id_r == INFO_TS_ID);
    wire len_zero = len_now == 16'h0000;

    // Submessage ends: pad or info timestamp with zero length, body count done, or message end
    wire end_pad = sub_hdr_end & len_zero & pad_like;
    wire end_trunc = sub_hdr_end & !len_zero & IN_LAST;
    wire end_tailnow = sub_hdr_end & len_zero & !pad_like & IN_LAST;
    wire end_body = in_body & fire & ((rem == 16'h0001) | IN_LAST);
    wire end_tail = in_tail & fire & IN_LAST;
    wire push = end_pad | end_trunc | end_tailnow | end_body | end_tail;
    wire sub_cut = in_sub & fire & IN_LAST & (cnt != rtps_frame_pkg::POS_SUB_LEN_B);
    wire hdr_cut = in_hdr & fire & IN_LAST & !hdr_bad;
    wire err_evt = (hdr_bad & enable) | sub_cut | hdr_cut;

    // Kind of the current identifier
    rtps_frame_pkg::kind_t kind;
    always_comb begin
        if (id_r >= rtps_frame_pkg::ID_VENDOR_FIRST) begin
            kind = rtps_frame_pkg::K_VENDOR;
        end else if (id_r == rtps_frame_pkg::ID_NACK_FRAG) begin
            kind = rtps_frame_pkg::K_NACK_FRAG;
        end else if (id_r == rtps_frame_pkg::ID_HEARTBEAT_FRAG) begin
            kind = rtps_frame_pkg::K_HEARTBEAT_FRAG;
        end else if (id_r == rtps_frame_pkg::ID_DATA) begin
            kind = rtps_frame_pkg::K_DATA;
        end else if (id_r == rtps_frame_pkg::ID_DATA_FRAG) begin
            kind = rtps_frame_pkg::K_DATA_FRAG;
        end else if (id_r == ACKNACK_ID) begin
            kind = rtps_frame_pkg::K_ACKNACK;
        end else if (id_r == PAD_ID) begin
            kind = rtps_frame_pkg::K_PAD;
        end else if (id_r == INFO_TS_ID) begin
            kind = rtps_frame_pkg::K_INFO_TS;
        end else begin
            kind = rtps_frame_pkg::K_PROTO_OTHER;
        end
    end

    // Descriptor: only defined flag bits feed the derived outputs
    wire ack_final = (kind == rtps_frame_pkg::K_ACKNACK) &&
                     ((flags_r & rtps_frame_pkg::FLAG_FINAL) != 8'h00);
    wire [15:0] desc_len = in_sub ? len_now : len_r;
    wire [rtps_frame_pkg::DESC_W+1:0] desc = {ack_final, little, vendor_r, kind,
                                             IN_LAST, id_r, flags_r, desc_len};
    wire [rtps_frame_pkg::DESC_W+1:0] buf_out;

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            rtps_frame_pkg::S_HDR: begin
                if (hdr_bad && !IN_LAST) begin
                    next_state = rtps_frame_pkg::S_DROP;
                end else if (hdr_done) begin
                    next_state = rtps_frame_pkg::S_SUB;
                end
            end
            rtps_frame_pkg::S_SUB: begin
                if (fire && IN_LAST) begin
                    next_state = rtps_frame_pkg::S_HDR;
                end else if (sub_hdr_end && !len_zero) begin
                    next_state = rtps_frame_pkg::S_BODY;
                end else if (sub_hdr_end && !pad_like) begin
                    next_state = rtps_frame_pkg::S_TAIL;
                end
            end
            rtps_frame_pkg::S_BODY: begin
                if (end_body) begin
                    next_state = IN_LAST ? rtps_frame_pkg::S_HDR : rtps_frame_pkg::S_SUB;
                end
            end
            rtps_frame_pkg::S_TAIL, rtps_frame_pkg::S_DROP: begin
                if (fire && IN_LAST) begin
                    next_state = rtps_frame_pkg::S_HDR;
                end
            end
            default: next_state = rtps_frame_pkg::S_DROP;
        endcase
    end

    // State and octet counters
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state <= rtps_frame_pkg::S_HDR;
            cnt <= 5'd0;
            rem <= 16'h0000;
        end else begin
            state <= next_state;
            if (fire) begin
                cnt <= (next_state != state || end_pad || IN_LAST) ? 5'd0 : cnt + 5'd1;
                rem <= sub_hdr_end ? len_now : rem - 16'h0001;
            end
        end
    end

    // Header and submessage header fields
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            id_r <= 8'h00;
            flags_r <= 8'h00;
            len_first <= 8'h00;
            len_r <= 16'h0000;
            vendor_r <= 16'h0000;
            major_r <= 8'h00;
        end else if (fire) begin
            if (in_hdr && cnt == rtps_frame_pkg::POS_MAJOR) major_r <= IN_DATA;
            if (in_hdr && cnt == rtps_frame_pkg::POS_VENDOR_HI) vendor_r[15:8] <= IN_DATA;
            if (in_hdr && cnt == rtps_frame_pkg::POS_VENDOR_LO) vendor_r[7:0] <= IN_DATA;
            if (in_sub && cnt == rtps_frame_pkg::POS_SUB_ID) id_r <= IN_DATA;
            if (in_sub && cnt == rtps_frame_pkg::POS_SUB_FLAGS) flags_r <= IN_DATA;
            if (in_sub && cnt == rtps_frame_pkg::POS_SUB_LEN_A) len_first <= IN_DATA;
            if (sub_hdr_end) len_r <= len_now;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Compact locator: first eight body octets, address then port
    wire loc_take = in_body & fire & (id_r == LOC_ID) & (bidx < rtps_frame_pkg::LOC_OCTETS);
    wire [4:0] lane = {bidx[1:0], 3'b000};

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            bidx <= 4'h0;
            LOC_VALID <= 1'b0;
            LOC_ADDR <= 32'h00000000;
            LOC_PORT <= 32'h00000000;
        end else begin
            LOC_VALID <= loc_take & (bidx == rtps_frame_pkg::LOC_OCTETS - 4'h1);
            if (sub_hdr_end) begin
                bidx <= 4'h0;
            end else if (loc_take) begin
                bidx <= bidx + 4'h1;
                if (!bidx[2] && little) LOC_ADDR[lane +: 8] <= IN_DATA;
                if (!bidx[2] && !little) LOC_ADDR <= {LOC_ADDR[23:0], IN_DATA};
                if (bidx[2] && little) LOC_PORT[lane +: 8] <= IN_DATA;
                if (bidx[2] && !little) LOC_PORT <= {LOC_PORT[23:0], IN_DATA};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Descriptor buffer; a full buffer stalls the byte input
    desc_buffer #(
        .W(rtps_frame_pkg::DESC_W + 2)
    ) u_buf (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data(desc),
        .in_ready(buf_ready),
        .out_valid(SUB_VALID),
        .out_data(buf_out),
        .out_ready(SUB_READY)
    );

    // Descriptor fields onto the output ports
    assign IN_READY = buf_ready;
    assign SUB_ACK_FINAL = buf_out[54];
    assign SUB_LITTLE = buf_out[53];
    assign SUB_VENDOR = buf_out[52:37];
    assign SUB_KIND = buf_out[36:33];
    assign SUB_MSG_END = buf_out[32];
    assign SUB_ID = buf_out[31:24];
    assign SUB_FLAGS = buf_out[23:16];
    assign SUB_LEN = buf_out[15:0];

    ////////////////////////////////////////////////////////////////////
    // Register port
    wire wr_ctrl = REG_WR & (REG_ADDR == rtps_frame_pkg::REG_CTRL);
    wire clr = wr_ctrl & REG_WDATA[rtps_frame_pkg::CTRL_CLEAR];
    wire [31:0] status_word = {8'h00, major_r, 13'h0000, state};
    wire [31:0] rd_mux =
        (REG_ADDR == rtps_frame_pkg::REG_CTRL) ? {31'h00000000, enable} :
        (REG_ADDR == rtps_frame_pkg::REG_STATUS) ? status_word :
        (REG_ADDR == rtps_frame_pkg::REG_SUB_COUNT) ? {vendor_r, sub_count} :
        (REG_ADDR == rtps_frame_pkg::REG_ERR_COUNT) ? {16'h0000, err_count} :
        32'h00000000;

    // Control, counters and read data; a count event in a clear cycle restarts the count at one
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            enable <= rtps_frame_pkg::CTRL_ENABLE_RESET;
            sub_count <= 16'h0000;
            err_count <= 16'h0000;
            REG_RDATA <= 32'h00000000;
        end else begin
            if (wr_ctrl) enable <= REG_WDATA[rtps_frame_pkg::CTRL_ENABLE];
            if (push) sub_count <= clr ? 16'h0001 : sub_count + 16'h0001;
            else if (clr) sub_count <= 16'h0000;
            if (err_evt) err_count <= clr ? 16'h0001 : err_count + 16'h0001;
            else if (clr) err_count <= 16'h0000;
            REG_RDATA <= REG_RD ? rd_mux : 32'h00000000;
        end
    end

endmodule : rtps_message_header_parser

// File: tb/rtps_parser_props.sv
/* Port checker for the message framing parser.
   Assumes it is bound into the parser top module. */
`timescale 1ns/1ps
module rtps_parser_props #(
    parameter logic [7:0] ACKNACK_ID = 8'h06,
    parameter logic [7:0] PAD_ID = 8'h01,
    parameter logic [7:0] INFO_TS_ID = 8'h09
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic SUB_VALID,
    input wire logic SUB_READY,
    input wire logic [7:0] SUB_ID,
    input wire logic [7:0] SUB_FLAGS,
    input wire logic [15:0] SUB_LEN,
    input wire logic [3:0] SUB_KIND,
    input wire logic SUB_LITTLE,
    input wire logic SUB_ACK_FINAL,
    input wire logic SUB_MSG_END,
    input wire logic LOC_VALID
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////
    // Descriptor holds, flags and kinds decode from the identifier
    hold_desc_a: assert property (SUB_VALID && !SUB_READY |=>
        SUB_VALID && $stable({SUB_ID, SUB_FLAGS, SUB_LEN, SUB_KIND}))
        else $error("descriptor changed while stalled");
    little_flag_a: assert property (SUB_VALID |-> SUB_LITTLE == SUB_FLAGS[0])
        else $error("byte order flag wrong");
    ack_final_a: assert property (SUB_VALID |-> SUB_ACK_FINAL ==
        (SUB_ID == ACKNACK_ID && SUB_FLAGS[1]))
        else $error("final flag wrong");
    vendor_kind_a: assert property (SUB_VALID |-> SUB_ID[7] ==
        (SUB_KIND == rtps_frame_pkg::K_VENDOR))
        else $error("vendor class wrong");
    proto_kind_a: assert property (SUB_VALID && !SUB_ID[7] |->
        SUB_KIND != rtps_frame_pkg::K_VENDOR)
        else $error("protocol id taken as vendor");
    frag_kind_a: assert property (SUB_VALID |->
        (SUB_ID == 8'h12) == (SUB_KIND == rtps_frame_pkg::K_NACK_FRAG)
        && (SUB_ID == 8'h13) == (SUB_KIND == rtps_frame_pkg::K_HEARTBEAT_FRAG))
        else $error("fragment kinds wrong");
    data_kind_a: assert property (SUB_VALID |->
        (SUB_ID == 8'h15) == (SUB_KIND == rtps_frame_pkg::K_DATA)
        && (SUB_ID == 8'h16) == (SUB_KIND == rtps_frame_pkg::K_DATA_FRAG))
        else $error("data kinds wrong");
    zero_len_a: assert property (SUB_VALID && SUB_LEN == 16'h0000
        && SUB_ID != PAD_ID && SUB_ID != INFO_TS_ID |-> SUB_MSG_END)
        else $error("zero length not last");
    loc_pulse_a: assert property (LOC_VALID |=> !LOC_VALID)
        else $error("locator pulse too long");
endmodule : rtps_parser_props

bind rtps_message_header_parser rtps_parser_props #(.ACKNACK_ID(ACKNACK_ID),
    .PAD_ID(PAD_ID), .INFO_TS_ID(INFO_TS_ID)) u_props (.*);

// File: tb/rtps_peer_model.sv
/* Remote participant: plays queued datagram octets onto the byte port.
   Assumes the bench fills the queue only after reset. */
`timescale 1ns/1ps
module rtps_peer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_last
);
    logic [8:0] q[$];
    logic gap = 1'b0;
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_last = 1'b0;
    end
    task push(input logic [7:0] b, input logic l);
        q.push_back({l, b});
    endtask : push
    // Octet held until taken; idle data toggles; slow mode idles every other cycle
    always @(posedge clk) begin
        gap <= slow && !gap;
        if (!rst_n) begin
            in_valid <= 1'b0;
        end else if (!(in_valid && !in_ready)) begin
            if (q.size() > 0 && !gap) begin
                {in_last, in_data} <= q.pop_front();
                in_valid <= 1'b1;
            end else begin
                in_valid <= 1'b0;
                in_last <= 1'b0;
                in_data <= ~in_data;
            end
        end
    end
endmodule : rtps_peer_model

// File: tb/test_rtps_message_header_parser.sv
/* Self-checking bench for the framing parser with a peer byte source.
   Assumes the package and the parser are compiled first. */
`timescale 1ns/1ps
module test_rtps_message_header_parser;
    localparam logic [7:0] ack_id = 8'h06, pad_id = 8'h01, ts_id = 8'h09, loc_id = 8'h0f;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, stall = 1'b0, keep = 1'b1;
    logic sub_ready = 1'b0, in_valid, in_last, in_ready, sub_valid, loc_valid;
    logic sub_little, sub_ack_final, sub_msg_end;
    logic [7:0] in_data, sub_id, sub_flags, reg_addr = 8'h00;
    logic [15:0] sub_len, sub_vendor, vendor, lfsr = 16'h001b, rl = 16'h001b;
    logic [3:0] sub_kind;
    logic [31:0] loc_addr, loc_port, reg_wdata = 32'h0, reg_rdata, rd;
    logic [54:0] exp_q[$];
    logic [63:0] loc_q[$];
    int fail_count = 0, checked = 0, n_sub = 0;
    always #25 clk_sys = ~clk_sys;
    rtps_message_header_parser u_dut (.CLK_SYS(clk_sys), .RESETN(resetn),
        .IN_VALID(in_valid), .IN_DATA(in_data), .IN_LAST(in_last), .IN_READY(in_ready),
        .SUB_VALID(sub_valid), .SUB_READY(sub_ready), .SUB_ID(sub_id), .SUB_FLAGS(sub_flags),
        .SUB_LEN(sub_len), .SUB_KIND(sub_kind), .SUB_VENDOR(sub_vendor),
        .SUB_LITTLE(sub_little), .SUB_ACK_FINAL(sub_ack_final), .SUB_MSG_END(sub_msg_end),
        .LOC_VALID(loc_valid), .LOC_ADDR(loc_addr), .LOC_PORT(loc_port), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    rtps_peer_model u_peer (.clk(clk_sys), .rst_n(resetn), .slow(slow),
        .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data), .in_last(in_last));
    ////////////////////////////////////////
    // Helpers: random source, expectations, compare, closing
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    function logic [7:0] rand8();
        lfsr = step(lfsr);
        return lfsr[7:0];
    endfunction : rand8
    function automatic logic [3:0] exp_kind(input logic [7:0] id);
        if (id[7]) return rtps_frame_pkg::K_VENDOR;
        case (id)
            8'h12: return rtps_frame_pkg::K_NACK_FRAG;
            8'h13: return rtps_frame_pkg::K_HEARTBEAT_FRAG;
            8'h15: return rtps_frame_pkg::K_DATA;
            8'h16: return rtps_frame_pkg::K_DATA_FRAG;
            ack_id: return rtps_frame_pkg::K_ACKNACK;
            pad_id: return rtps_frame_pkg::K_PAD;
            ts_id: return rtps_frame_pkg::K_INFO_TS;
            default: return rtps_frame_pkg::K_PROTO_OTHER;
        endcase
    endfunction : exp_kind
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task end_of_test();
        $display("mismatches %0d, checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Message header, then submessages with expectations
    task automatic hdr(input logic [7:0] m3, input logic [7:0] major);
        logic [7:0] h[8];
        vendor = {rand8(), rand8()};
        h = '{rtps_frame_pkg::MAGIC_0, rtps_frame_pkg::MAGIC_1, rtps_frame_pkg::MAGIC_2,
            m3, major, 8'h01, vendor[15:8], vendor[7:0]};
        foreach (h[i]) u_peer.push(h[i], 1'b0);
        repeat (12) u_peer.push(rand8(), 1'b0);
    endtask : hdr
    task automatic sub(input logic [7:0] id, input logic [7:0] fl, input logic [15:0] len,
        input int nb, input logic fin);
        logic [7:0] bb[8];
        logic [3:0] k;
        k = exp_kind(id);
        if (keep) begin
            exp_q.push_back({vendor, k, id, fl, len, fl[0], k == 4'h5 && fl[1], fin});
            n_sub++;
        end
        u_peer.push(id, 1'b0);
        u_peer.push(fl, 1'b0);
        u_peer.push(fl[0] ? len[7:0] : len[15:8], 1'b0);
        u_peer.push(fl[0] ? len[15:8] : len[7:0], fin && nb == 0);
        for (int i = 0; i < nb; i++) begin
            bb[i % 8] = (i < 8) ? rand8() : bb[i % 8];
            u_peer.push(bb[i % 8], fin && i == nb - 1);
        end
        if (keep && id == loc_id && nb >= 8) begin
            loc_q.push_back(fl[0] ? {bb[3], bb[2], bb[1], bb[0], bb[7], bb[6], bb[5], bb[4]}
                : {bb[0], bb[1], bb[2], bb[3], bb[4], bb[5], bb[6], bb[7]});
        end
    endtask : sub
    task automatic settle();
        int n;
        for (n = 0; n < 4000 && (exp_q.size() > 0 || u_peer.q.size() > 0); n++)
            @(posedge clk_sys);
        if (n == 4000) begin
            check(0, 1, "wait ran out");
            end_of_test();
        end
        repeat (30) @(posedge clk_sys);
    endtask : settle
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd = reg_rdata;
    endtask : reg_read
    // Consumer with random stalls; descriptor and locator monitors
    always @(posedge clk_sys) begin
        rl <= step(rl);
        sub_ready <= !stall && (rl[0] || rl[3]);
        if (sub_valid && sub_ready) check({sub_vendor, sub_kind, sub_id, sub_flags, sub_len,
            sub_little, sub_ack_final, sub_msg_end}, exp_q.pop_front(), "descriptor");
        if (loc_valid) check({loc_addr, loc_port}, loc_q.pop_front(), "locator");
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        check(0, 1, "run limit");
        end_of_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_read(rtps_frame_pkg::REG_CTRL);
        check(rd, 1, "control reset");
        reg_read(8'h10);
        check(rd, 0, "unmapped read");
        hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
        sub(8'h15, 8'h00, 3, 3, 0);
        sub(8'h16, 8'h01, 2, 2, 0);
        sub(8'h12, 8'h01, 4, 4, 0);
        sub(8'h13, 8'h00, 1, 1, 0);
        sub(ack_id, 8'h03, 4, 4, 0);
        sub(ack_id, 8'hfd, 4, 4, 0);
        sub(pad_id, 8'h00, 0, 0, 0);
        sub(ts_id, 8'h01, 0, 0, 0);
        sub(8'h7f, 8'h00, 2, 2, 0);
        sub(8'h80, 8'h00, 1, 1, 0);
        sub(8'hff, 8'hfe, 2, 2, 0);
        sub(loc_id, 8'h00, 8, 8, 0);
        sub(loc_id, 8'h01, 8, 8, 0);
        sub(8'h15, 8'h01, 0, 5, 1);
        hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
        sub(8'h15, 8'h00, 3, 3, 0);
        sub(8'h16, 8'h01, 5, 5, 1);
        hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
        sub(pad_id, 8'h00, 0, 0, 1);
        settle();
        keep = 1'b0;
        hdr(8'h58, rtps_frame_pkg::VERSION_MAJOR);
        sub(8'h15, 8'h00, 2, 2, 1);
        hdr(rtps_frame_pkg::MAGIC_3, 8'h03);
        sub(8'h15, 8'h00, 2, 2, 1);
        settle();
        reg_read(rtps_frame_pkg::REG_ERR_COUNT);
        check(rd[15:0], 2, "error count");
        reg_read(rtps_frame_pkg::REG_SUB_COUNT);
        check(rd[15:0], n_sub, "descriptor count");
        reg_write(rtps_frame_pkg::REG_CTRL, 32'h3);
        reg_write(rtps_frame_pkg::REG_CTRL, 32'h0);
        hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
        sub(8'h15, 8'h00, 2, 2, 1);
        settle();
        reg_read(rtps_frame_pkg::REG_SUB_COUNT);
        check(rd[15:0], 0, "count while disabled");
        reg_read(rtps_frame_pkg::REG_ERR_COUNT);
        check(rd[15:0], 0, "errors cleared");
        reg_write(rtps_frame_pkg::REG_CTRL, 32'h1);
        keep = 1'b1;
        stall = 1'b1;
        hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
        for (int i = 0; i < 6; i++) sub(8'h15, 8'h00, 1, 1, i == 5);
        for (int n = 0; n < 400 && in_ready; n++) @(posedge clk_sys);
        check(in_ready, 0, "input refused when full");
        stall = 1'b0;
        settle();
        // Random messages of random submessages, peer pace varied
        for (int m = 0; m < 20; m++) begin
            logic [7:0] id, fl, ln;
            slow = m[0];
            hdr(rtps_frame_pkg::MAGIC_3, rtps_frame_pkg::VERSION_MAJOR);
            for (int s = 0; s < 4; s++) begin
                id = rand8();
                fl = rand8();
                ln = {4'h0, rand8() & 8'h0f} + 8'h01;
                sub(id, fl, {8'h00, ln}, ln, s == 3);
            end
        end
        settle();
        reg_read(rtps_frame_pkg::REG_STATUS);
        check(rd, 32'h00020000, "status");
        end_of_test();
    end
endmodule : test_rtps_message_header_parser
